// file: sad_pkg.sv
// Purpose: shared constants and types for the stereo audio delay link
// Assumes: host clock 100 MHz, link bit clock made by the host divider
// Notes: both ends import this package whole
package sad_pkg;
	localparam int SAD_CLK_NS = 10;
	localparam int SAD_BCLK_NS = 80;
	localparam int SAD_BCLK_HALF = SAD_BCLK_NS / (2 * SAD_CLK_NS);
	localparam logic [1:0] SAD_DIV_LAST = 2'(SAD_BCLK_HALF - 1);
	localparam int SAD_I2C_QTR_NS = 625;
	localparam int SAD_I2C_QTR = (SAD_I2C_QTR_NS + SAD_CLK_NS - 1) / SAD_CLK_NS;
	localparam logic [6:0] SAD_QTR_LAST = 7'(SAD_I2C_QTR - 1);
	localparam logic [3:0] SAD_ADDR_FIXED = 4'hd;
	localparam logic [7:0] SAD_REG_CTRL = 8'h01;
	localparam logic [7:0] SAD_REG_RDLY_HI = 8'h02;
	localparam logic [7:0] SAD_REG_RDLY_LO = 8'h03;
	localparam logic [7:0] SAD_REG_LDLY_HI = 8'h04;
	localparam logic [7:0] SAD_REG_LDLY_LO = 8'h05;
	localparam int SAD_DLY_W = 13;
	localparam int SAD_MEM_DEPTH = 8192;
	localparam logic [13:0] SAD_FILL_MAX = 14'h2000;
	localparam int SAD_MUTE_L_BIT = 6;
	localparam int SAD_MUTE_R_BIT = 7;
	localparam int SAD_SMP_W = 24;
	localparam logic [5:0] SAD_SLOT_MAX = 6'h20;
	localparam logic [5:0] SAD_CNT_ONE = 6'h01;
	localparam logic [5:0] SAD_FRAME_LAST = 6'h3f;
	localparam logic [4:0] SAD_SMP_P = 5'h18;
	localparam logic [4:0] SAD_SMP_LAST = 5'h17;
	localparam logic [4:0] SAD_RJ_PAD = 5'h08;
	localparam logic [4:0] SAD_SLOT_LAST = 5'h1f;
	localparam logic [3:0] SAD_ACK_CNT = 4'h8;
	localparam logic [3:0] SAD_END_CNT = 4'h9;
	localparam logic [4:0] SAD_ACK0 = 5'h08;
	localparam logic [4:0] SAD_ACK1 = 5'h11;
	localparam logic [4:0] SAD_ACK2 = 5'h1a;
	typedef enum logic [1:0] {
		SAD_FMT_I2S = 2'b00,
		SAD_FMT_RJ = 2'b01,
		SAD_FMT_LJ = 2'b10,
		SAD_FMT_BYP = 2'b11
	} sad_fmt_e;
	typedef enum logic [2:0] {
		SAD_S_IDLE = 3'b000,
		SAD_S_ADDR = 3'b001,
		SAD_S_REG = 3'b010,
		SAD_S_DATA = 3'b011,
		SAD_S_SKIP = 3'b100
	} sad_slv_e;
	typedef enum logic [1:0] {
		SAD_M_IDLE = 2'b00,
		SAD_M_START = 2'b01,
		SAD_M_BIT = 2'b10,
		SAD_M_STOP = 2'b11
	} sad_mst_e;
endpackage : sad_pkg

// file: sad_if.sv
// Purpose: audio and control bus wires between source/master and delay device
// Assumes: open-drain data line resolved here from the two enables
// Notes: clock line driven by the master only, no stretching
interface sad_if;
	logic bclk;
	logic lrclk;
	logic sdata;
	logic data_out;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic sda;
	// wired-and with pull-up
	assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
	modport host (
		output bclk,
		output lrclk,
		output sdata,
		output scl,
		output sda_m_o,
		output sda_m_oe,
		input data_out,
		input sda
	);
	modport dev (
		input bclk,
		input lrclk,
		input sdata,
		input scl,
		input sda,
		output data_out,
		output sda_s_o,
		output sda_s_oe
	);
endinterface : sad_if

// file: sad_host.sv
// Purpose: audio source and control bus master facing the delay device
// Assumes: 100 MHz clk, bit clock divided down, 64 bit clocks per frame
// Notes: one register byte per control transfer
module sad_host
	import sad_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	sad_if.host lnk,
	input wire logic [1:0] fmt,
	input wire logic [SAD_SMP_W-1:0] smp_left,
	input wire logic [SAD_SMP_W-1:0] smp_right,
	output logic smp_take,
	input wire logic wr_valid,
	input wire logic [6:0] wr_dev,
	input wire logic [7:0] wr_reg,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	output logic wr_done,
	output logic wr_nack
);
	logic [1:0] div;
	logic bclk_fall;
	logic [5:0] pos;
	logic [SAD_SMP_W-1:0] lat_l;
	logic [SAD_SMP_W-1:0] lat_r;
	sad_mst_e mst;
	logic [1:0] ph;
	logic [6:0] qcnt;
	logic tick;
	logic [4:0] bn;
	logic [26:0] tx;
	logic sda1;
	logic sda2;

	function automatic logic host_bit(input logic [1:0] f, input logic [SAD_SMP_W-1:0] w, input logic [4:0] p);
		logic b;
		b = 1'b0;
		case (sad_fmt_e'(f))
			SAD_FMT_LJ: if (p < SAD_SMP_P) b = w[SAD_SMP_LAST - p];
			SAD_FMT_RJ: if (p >= SAD_RJ_PAD) b = w[SAD_SLOT_LAST - p];
			default: if (p != 5'h00 && p <= SAD_SMP_P) b = w[SAD_SMP_P - p];
		endcase
		return b;
	endfunction : host_bit

	// link clock is ours: divided down, data moves on its falling edge
	assign bclk_fall = lnk.bclk && div == SAD_DIV_LAST;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div <= 2'h0;
			lnk.bclk <= 1'b0;
		end else if (div == SAD_DIV_LAST) begin
			div <= 2'h0;
			lnk.bclk <= ~lnk.bclk;
		end else begin
			div <= div + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos <= 6'h00;
			lnk.lrclk <= 1'b0;
			lnk.sdata <= 1'b0;
		end else if (bclk_fall) begin
			lnk.lrclk <= (sad_fmt_e'(fmt) == SAD_FMT_I2S) ? pos[5] : ~pos[5];
			lnk.sdata <= host_bit(fmt, pos[5] ? lat_r : lat_l, pos[4:0]);
			pos <= pos + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lat_l <= '0;
			lat_r <= '0;
			smp_take <= 1'b0;
		end else begin
			smp_take <= bclk_fall && pos == SAD_FRAME_LAST;
			if (bclk_fall && pos == SAD_FRAME_LAST) begin
				lat_l <= smp_left;
				lat_r <= smp_right;
			end
		end
	end

	// bus data line is asynchronous to us
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda1 <= 1'b1;
			sda2 <= 1'b1;
		end else begin
			sda1 <= lnk.sda;
			sda2 <= sda1;
		end
	end

	assign tick = qcnt == SAD_QTR_LAST;
	always_ff @(posedge clk) begin
		if (!rst_n || mst == SAD_M_IDLE || tick) qcnt <= 7'h00;
		else qcnt <= qcnt + 7'h01;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mst <= SAD_M_IDLE;
			ph <= 2'h0;
			bn <= 5'h00;
			tx <= '0;
			lnk.scl <= 1'b1;
			lnk.sda_m_oe <= 1'b0;
			lnk.sda_m_o <= 1'b0;
			wr_ready <= 1'b0;
			wr_done <= 1'b0;
			wr_nack <= 1'b0;
		end else begin
			wr_done <= 1'b0;
			case (mst)
				SAD_M_IDLE: begin
					wr_ready <= ~wr_valid;
					if (wr_valid && wr_ready) begin
						mst <= SAD_M_START;
						ph <= 2'h0;
						bn <= 5'h00;
						wr_nack <= 1'b0;
						wr_ready <= 1'b0;
						// ack slots released as ones
						tx <= {wr_dev, 1'b0, 1'b1, wr_reg, 1'b1, wr_data, 1'b1};
					end
				end
				SAD_M_START: if (tick) begin
					ph <= ph + 2'h1;
					if (ph == 2'h1) lnk.sda_m_oe <= 1'b1;
					if (ph == 2'h2) begin
						lnk.scl <= 1'b0;
						mst <= SAD_M_BIT;
						ph <= 2'h0;
					end
				end
				SAD_M_BIT: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: lnk.sda_m_oe <= ~tx[26];
						2'h1: lnk.scl <= 1'b1;
						2'h2: if ((bn == SAD_ACK0 || bn == SAD_ACK1 || bn == SAD_ACK2) && sda2) wr_nack <= 1'b1;
						default: begin
							lnk.scl <= 1'b0;
							tx <= {tx[25:0], 1'b1};
							if (bn == SAD_ACK2) mst <= SAD_M_STOP;
							else bn <= bn + 5'h01;
						end
					endcase
				end
				default: if (tick) begin
					ph <= ph + 2'h1;
					case (ph)
						2'h0: lnk.sda_m_oe <= 1'b1;
						2'h1: lnk.scl <= 1'b1;
						2'h2: lnk.sda_m_oe <= 1'b0;
						default: begin
							mst <= SAD_M_IDLE;
							wr_done <= 1'b1;
						end
					endcase
				end
			endcase
		end
	end
endmodule : sad_host

// file: sad_dev.sv
// Purpose: serial audio delay device with control bus slave
// Assumes: everything runs on the audio bit clock, no system clock
// Notes: output lags input framing by one frame plus the set delay and half a bit clock; in bypass by half a bit clock only
// Functional notes
// - sample audio data on bit clock rise
// - word clock edge moves word into storage
// - 32 to 64 bit clocks per frame
// - all timing from audio clocks only
// - three formats, selected over control bus
// - word clock polarity depends on format
// - sample words of 16 to 24 bits
// - per channel delay in whole samples
// - buffer cleared at reset or delay change (code resets write pointers and fill counts, not the memory)
// - delayed audio on one serial output
// - bytes MSB first, each byte acknowledged
// - data edges with clock high: start/stop
// - master changes data only clock low
// - master frames transfers with start, stop
// - ack low for address match and bytes
// - unlimited bytes per transfer
// - address is 1101 then three straps
// - register pointer then auto incrementing writes
// - low control bits pick format or bypass
module sad_dev
	import sad_pkg::*;
(
	input wire logic bclk,
	input wire logic rst_n,
	input wire logic addr_select_msb,
	input wire logic addr_select_mid,
	input wire logic addr_select_lsb,
	sad_if.dev lnk,
	output logic [7:0] cfg_ctrl,
	output logic [SAD_DLY_W-1:0] cfg_dly_l,
	output logic [SAD_DLY_W-1:0] cfg_dly_r
);
	logic [2:0] strap1;
	logic [2:0] strap2;
	logic scl1;
	logic scl2;
	logic scl3;
	logic sda1;
	logic sda2;
	logic sda3;
	logic [6:0] my_addr;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	sad_slv_e st;
	logic [3:0] bcnt;
	logic [7:0] sh;
	logic [7:0] ptr;
	logic byte_done;
	logic ack_now;
	logic wr_en;
	logic dly_chg;
	sad_fmt_e fmt;
	logic lr_q;
	logic lr_edge;
	logic done_left;
	logic [31:0] sin;
	logic [31:0] osr;
	logic [5:0] scnt;
	logic [SAD_DLY_W-1:0] wp_l;
	logic [SAD_DLY_W-1:0] wp_r;
	logic [13:0] fill_l;
	logic [13:0] fill_r;
	logic [31:0] mem_l [0:SAD_MEM_DEPTH-1];
	logic [31:0] mem_r [0:SAD_MEM_DEPTH-1];
	logic [31:0] rd_word;
	logic rd_ok;
	logic [31:0] load_word;

	function automatic logic is_left(input sad_fmt_e f, input logic lr);
		return (f == SAD_FMT_I2S) ? ~lr : lr;
	endfunction : is_left

	function automatic logic [SAD_DLY_W-1:0] rd_idx(input logic [SAD_DLY_W-1:0] wp, input logic [SAD_DLY_W-1:0] d);
		return wp - 13'h0001 - d;
	endfunction : rd_idx

	// bus pins and straps are asynchronous to the bit clock
	always_ff @(posedge bclk) begin
		if (!rst_n) begin
			strap1 <= 3'h0;
			strap2 <= 3'h0;
			scl1 <= 1'b1;
			scl2 <= 1'b1;
			scl3 <= 1'b1;
			sda1 <= 1'b1;
			sda2 <= 1'b1;
			sda3 <= 1'b1;
		end else begin
			strap1 <= {addr_select_msb, addr_select_mid, addr_select_lsb};
			strap2 <= strap1;
			scl1 <= lnk.scl;
			scl2 <= scl1;
			scl3 <= scl2;
			sda1 <= lnk.sda;
			sda2 <= sda1;
			sda3 <= sda2;
		end
	end

	assign my_addr = {SAD_ADDR_FIXED, strap2};
	assign scl_rise = scl2 & ~scl3;
	assign scl_fall = ~scl2 & scl3;
	assign bus_start = scl2 & scl3 & sda3 & ~sda2;
	assign bus_stop = scl2 & scl3 & ~sda3 & sda2;
	assign byte_done = scl_fall && bcnt == SAD_ACK_CNT;
	assign wr_en = byte_done && st == SAD_S_DATA;
	// read direction is acked but answers nothing: bus floats high
	assign ack_now = (st == SAD_S_ADDR && sh[7:1] == my_addr) || st == SAD_S_REG || st == SAD_S_DATA;

	always_ff @(posedge bclk) begin
		if (!rst_n) begin
			st <= SAD_S_IDLE;
		end else if (bus_start) begin
			st <= SAD_S_ADDR;
		end else if (bus_stop) begin
			st <= SAD_S_IDLE;
		end else if (byte_done) begin
			case (st)
				SAD_S_ADDR: st <= (sh[7:1] != my_addr || sh[0]) ? SAD_S_SKIP : SAD_S_REG;
				SAD_S_REG: st <= SAD_S_DATA;
				default: st <= st;
			endcase
		end
	end

	always_ff @(posedge bclk) begin
		if (!rst_n || bus_start || bus_stop) begin
			bcnt <= 4'h0;
		end else if (scl_rise && bcnt != SAD_END_CNT) begin
			bcnt <= bcnt + 4'h1;
		end else if (scl_fall && bcnt == SAD_END_CNT) begin
			bcnt <= 4'h0;
		end
	end

	always_ff @(posedge bclk) begin
		if (!rst_n) sh <= 8'h00;
		else if (scl_rise && bcnt < SAD_ACK_CNT) sh <= {sh[6:0], sda2};
	end

	// drive only from the fall after bit 8 to the fall after the ack clock
	always_ff @(posedge bclk) begin
		lnk.sda_s_o <= 1'b0;
		if (!rst_n || bus_start || bus_stop) lnk.sda_s_oe <= 1'b0;
		else if (byte_done) lnk.sda_s_oe <= ack_now;
		else if (scl_fall && bcnt == SAD_END_CNT) lnk.sda_s_oe <= 1'b0;
	end

	always_ff @(posedge bclk) begin
		if (!rst_n) ptr <= 8'h00;
		else if (byte_done && st == SAD_S_REG) ptr <= sh;
		else if (wr_en) ptr <= ptr + 8'h01;
	end

	always_ff @(posedge bclk) begin
		if (!rst_n) begin
			cfg_ctrl <= 8'h00;
			cfg_dly_l <= '0;
			cfg_dly_r <= '0;
			dly_chg <= 1'b1;
		end else begin
			dly_chg <= 1'b0;
			if (wr_en) begin
				case (ptr)
					SAD_REG_CTRL: cfg_ctrl <= sh;
					SAD_REG_RDLY_HI: begin
						cfg_dly_r[12:8] <= sh[4:0];
						dly_chg <= cfg_dly_r[12:8] != sh[4:0];
					end
					SAD_REG_RDLY_LO: begin
						cfg_dly_r[7:0] <= sh;
						dly_chg <= cfg_dly_r[7:0] != sh;
					end
					SAD_REG_LDLY_HI: begin
						cfg_dly_l[12:8] <= sh[4:0];
						dly_chg <= cfg_dly_l[12:8] != sh[4:0];
					end
					SAD_REG_LDLY_LO: begin
						cfg_dly_l[7:0] <= sh;
						dly_chg <= cfg_dly_l[7:0] != sh;
					end
					default: dly_chg <= 1'b0;
				endcase
			end
		end
	end

	assign fmt = sad_fmt_e'(cfg_ctrl[1:0]);
	assign lr_edge = lnk.lrclk != lr_q;
	assign done_left = is_left(fmt, lr_q);

	// whole slot kept, so any word length and justification replays unchanged
	always_ff @(posedge bclk) begin
		if (!rst_n) begin
			lr_q <= 1'b0;
			sin <= '0;
			scnt <= 6'h00;
		end else begin
			lr_q <= lnk.lrclk;
			sin <= {sin[30:0], lnk.sdata};
			if (lr_edge) scnt <= SAD_CNT_ONE;
			else if (scnt != SAD_SLOT_MAX) scnt <= scnt + 6'h01;
		end
	end

	always_ff @(posedge bclk) begin
		if (lr_edge && done_left) mem_l[wp_l] <= sin;
		if (lr_edge && !done_left) mem_r[wp_r] <= sin;
	end

	// fill count stands in for clearing: unwritten slots never reach the pin
	always_ff @(posedge bclk) begin
		if (!rst_n || dly_chg) begin
			wp_l <= '0;
			wp_r <= '0;
			fill_l <= 14'h0000;
			fill_r <= 14'h0000;
		end else if (lr_edge) begin
			if (done_left) begin
				wp_l <= wp_l + 13'h0001;
				if (fill_l != SAD_FILL_MAX) fill_l <= fill_l + 14'h0001;
			end else begin
				wp_r <= wp_r + 13'h0001;
				if (fill_r != SAD_FILL_MAX) fill_r <= fill_r + 14'h0001;
			end
		end
	end

	always_comb begin
		if (done_left) begin
			rd_word = mem_r[rd_idx(wp_r, cfg_dly_r)];
			rd_ok = fill_r > {1'b0, cfg_dly_r} && !cfg_ctrl[SAD_MUTE_R_BIT];
		end else begin
			rd_word = mem_l[rd_idx(wp_l, cfg_dly_l)];
			rd_ok = fill_l > {1'b0, cfg_dly_l} && !cfg_ctrl[SAD_MUTE_L_BIT];
		end
	end

	// assumes both slots of a frame have the same length
	assign load_word = rd_ok ? rd_word << (SAD_SLOT_MAX - scnt) : 32'h0000_0000;

	always_ff @(posedge bclk) begin
		if (!rst_n) begin
			lnk.data_out <= 1'b0;
			osr <= '0;
		end else if (fmt == SAD_FMT_BYP) begin
			lnk.data_out <= lnk.sdata;
			osr <= '0;
		end else if (lr_edge) begin
			{lnk.data_out, osr} <= {load_word, 1'b0};
		end else begin
			{lnk.data_out, osr} <= {osr, 1'b0};
		end
	end
endmodule : sad_dev

// file: sad_chk.sv
// Purpose: link assertions for the audio delay host and device
// Assumes: host side on clk, device side on the bit clock
// Notes: instantiated beside the link, no bind
module sad_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rst_dev_n,
	input wire logic bclk,
	input wire logic lrclk,
	input wire logic sdata,
	input wire logic data_out,
	input wire logic scl,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic sda
);
	logic lr_q;
	logic seen;
	logic [6:0] cnt;
	// first word clock rise after reset only arms the count
	always_ff @(posedge bclk) begin
		if (!rst_dev_n) begin
			lr_q <= 1'b0;
			seen <= 1'b0;
			cnt <= 7'h00;
		end else begin
			lr_q <= lrclk;
			if (lrclk && !lr_q) begin
				seen <= 1'b1;
				cnt <= 7'h01;
			end else if (cnt != 7'h7f) begin
				cnt <= cnt + 7'h01;
			end
		end
	end
	chk_frame_span: assert property (@(posedge bclk) disable iff (!rst_dev_n)
		lrclk && !lr_q && seen |-> cnt >= 7'h20 && cnt <= 7'h40)
		else $error("frame length outside 32 to 64 bit clocks");
	chk_audio_setup: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(sdata) || $changed(lrclk) |-> $fell(bclk))
		else $error("audio input moved near a bit clock rise");
	chk_dout_edge: assert property (@(posedge clk) disable iff (!rst_n || !rst_dev_n)
		$changed(data_out) |-> $rose(bclk))
		else $error("data_out moved away from a bit clock rise");
	chk_start_hold: assert property (@(posedge clk) disable iff (!rst_n)
		scl && $fell(sda) |-> scl[*8])
		else $error("clock dropped right after start");
	chk_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
		scl && $rose(sda) |-> (scl && sda)[*8])
		else $error("bus not idle after stop");
	chk_ack_low: assert property (@(posedge bclk) disable iff (!rst_dev_n)
		sda_s_oe |-> !sda_s_o && !sda)
		else $error("acknowledge not driven low");
	chk_ack_rise: assert property (@(posedge bclk) disable iff (!rst_dev_n)
		$rose(sda_s_oe) |-> !scl ##1 sda_s_oe[*8])
		else $error("acknowledge started badly or too short");
	chk_ack_release: assert property (@(posedge bclk) disable iff (!rst_dev_n)
		$fell(sda_s_oe) |-> !scl)
		else $error("acknowledge released while clock high");
endmodule : sad_chk

// file: sad_test.sv
// Purpose: self-checking bench for the audio delay host and device pair
// Assumes: bit clock from the host divider, 64 bit clocks per frame
// Notes: samples held constant so the replayed stream repeats every frame
module sad_test
	import sad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// seven control writes of about 7300 cycles plus at most 63 frames of 512
	localparam int WD_CYCLES = 95000;
	localparam int FRAME = 64;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rst_dev_n = 1'b0;
	logic [1:0] fmt = 2'b00;
	logic [SAD_SMP_W-1:0] smp_l = '0;
	logic [SAD_SMP_W-1:0] smp_r = '0;
	logic wr_valid = 1'b0;
	logic [6:0] wr_dev = 7'h00;
	logic [7:0] wr_reg = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [2:0] strap = 3'h0;
	logic [7:0] d;
	logic wr_ready;
	logic wr_done;
	logic wr_nack;
	logic [7:0] cfg_ctrl;
	logic [SAD_DLY_W-1:0] dly_l;
	logic [SAD_DLY_W-1:0] dly_r;
	int fails = 0;
	int n_compared = 0;
	sad_fmt_e order[4] = '{SAD_FMT_BYP, SAD_FMT_RJ, SAD_FMT_LJ, SAD_FMT_I2S};

	sad_if sad_if_i();
	sad_host sad_host_i(.clk(clk), .rst_n(rst_n), .lnk(sad_if_i.host), .fmt(fmt), .smp_left(smp_l),
		.smp_right(smp_r), .smp_take(), .wr_valid(wr_valid), .wr_dev(wr_dev), .wr_reg(wr_reg),
		.wr_data(wr_data), .wr_ready(wr_ready), .wr_done(wr_done), .wr_nack(wr_nack));
	sad_dev sad_dev_i(.bclk(sad_if_i.bclk), .rst_n(rst_dev_n), .addr_select_msb(strap[2]),
		.addr_select_mid(strap[1]), .addr_select_lsb(strap[0]), .lnk(sad_if_i.dev),
		.cfg_ctrl(cfg_ctrl), .cfg_dly_l(dly_l), .cfg_dly_r(dly_r));
	sad_chk sad_chk_i(.clk(clk), .rst_n(rst_n), .rst_dev_n(rst_dev_n), .bclk(sad_if_i.bclk),
		.lrclk(sad_if_i.lrclk), .sdata(sad_if_i.sdata), .data_out(sad_if_i.data_out), .scl(sad_if_i.scl),
		.sda_s_o(sad_if_i.sda_s_o), .sda_s_oe(sad_if_i.sda_s_oe), .sda(sad_if_i.sda));

	always #(SAD_CLK_NS / 2) clk = ~clk;

	task automatic final_report();
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// left slot muted, except in bypass
	function automatic logic [7:0] ctrl_of(input sad_fmt_e f);
		return {1'b0, f != SAD_FMT_BYP, 4'h0, f};
	endfunction : ctrl_of

	function automatic logic exp_bit(input logic mute_l, input logic left_lvl, input logic zero,
		input logic lr, input logic sd);
		return (zero || (mute_l && lr === left_lvl)) ? 1'b0 : sd;
	endfunction : exp_bit

	// entered 1 ns after a clk edge; one register byte per transfer
	task automatic ctl_write(input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] dat,
		input logic nack);
		int n;
		n = 0;
		while (wr_ready !== 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 1000) begin
			fails++;
			final_report();
		end
		wr_valid = 1'b1;
		wr_dev = dev;
		wr_reg = rg;
		wr_data = dat;
		@(posedge clk);
		#1;
		wr_valid = 1'b0;
		n = 0;
		while (wr_done !== 1'b1 && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20000) begin
			fails++;
			final_report();
		end
		cmp("wr_nack", 32'(nack), 32'(wr_nack));
	endtask : ctl_write

	// constant samples: steady output equals the input slot, half a bit clock later
	task automatic chk_stream(input logic mute_l, input logic left_lvl, input logic zero);
		repeat (2 * FRAME) begin
			@(posedge sad_if_i.bclk);
			#1;
			cmp("data_out", 32'(exp_bit(mute_l, left_lvl, zero, sad_if_i.lrclk, sad_if_i.sdata)),
				32'(sad_if_i.data_out));
		end
	endtask : chk_stream

	initial begin
		#(WD_CYCLES * SAD_CLK_NS);
		fails++;
		final_report();
	end

	initial begin
		void'($urandom(77725));
		strap = 3'($urandom());
		smp_l = SAD_SMP_W'($urandom());
		smp_r = SAD_SMP_W'($urandom());
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		// device reset needs running bit clocks, so it is released later
		repeat (60) @(posedge clk);
		#1 rst_dev_n = 1'b1;
		repeat (40) @(posedge clk);
		#1;
		cmp("ctrl_rst", 32'h0, 32'(cfg_ctrl));
		cmp("dly_rst", 32'h0, 32'({dly_l, dly_r}));
		ctl_write({SAD_ADDR_FIXED, strap ^ 3'(1 << ($urandom() % 3))}, SAD_REG_CTRL, 8'h41, 1'b1);
		cmp("ctrl_foreign", 32'h0, 32'(cfg_ctrl));
		// host framing kept I2S except in bypass, where its word clock is inverted; otherwise only the device decode changes
		foreach (order[i]) begin
			fmt = (order[i] == SAD_FMT_BYP) ? 2'b11 : 2'b00;
			ctl_write({SAD_ADDR_FIXED, strap}, SAD_REG_CTRL, ctrl_of(order[i]), 1'b0);
			cmp("cfg_ctrl", 32'(ctrl_of(order[i])), 32'(cfg_ctrl));
			repeat (4 * FRAME) @(posedge sad_if_i.bclk);
			#1;
			chk_stream(order[i] != SAD_FMT_BYP, order[i] != SAD_FMT_I2S, 1'b0);
		end
		d = 8'(20 + $urandom() % 10);
		ctl_write({SAD_ADDR_FIXED, strap}, SAD_REG_RDLY_LO, d, 1'b0);
		ctl_write({SAD_ADDR_FIXED, strap}, SAD_REG_LDLY_LO, d, 1'b0);
		cmp("dly", 32'({5'h0, d, 5'h0, d}), 32'({dly_l, dly_r}));
		chk_stream(1'b1, 1'b0, 1'b1);
		repeat ((32'(d) + 6) * FRAME) @(posedge sad_if_i.bclk);
		#1;
		chk_stream(1'b1, 1'b0, 1'b0);
		final_report();
	end
endmodule : sad_test
